// ==== hw/csrc_pkg.sv ====
// Constants for the current source register bank
// Behaviour
// R1: Control bit 16 picks event channel or software bit as output enable source.
// R2: Control bit 14 disables bus mastering; block only monitors, own selection ignored.
// R3: Control bit 13 holds off stop-mode entry until output is stable.
// R4: Control bit 12 selects supply: 0 analog, 1 I/O; resets to 0.
// R5: Bits 11:4 select channel 0x20+n, even on X, odd on Y; reset 0x00.
// R6: Control bit 3 enables output only while event control is cleared.
// R7: Control bit 2 enables minimum output transition mode; resets to 0. The code passes it on only while output enable is off.
// R8: Control bit 1 set sinks current; cleared sources current.
// R9: Current program bits 1:0 select range 0 to 3; reset 0.
// R10: Duty config bit 1 disables duty cycling in stop mode; reset 0.
// R11: Status bit 1 reads 1 while a requested bus is also requested elsewhere. The code sets it in master mode only, with control bit 14 clear.
// R12: Flag register at 0x020 holds conflict flag at bit 1, read-only.
// R13: Writing 1 to flag-set bits sets conflict or settled flag; 0 ignored.
// R14: Writing 1 to flag-clear bits clears the flags; 0 ignored.
// R15: With read-clear enabled, reading flag-clear returns and clears flags.
// R16: Enable register at 0x02C: bit 1 conflict, bit 0 settled; reset 0.
// R17: Request status bit 3 reads 1 while Y half-bus requested.
// R18: Control bits 23:20 select event channel 0 to 11.
// R19: Master mode conflict on driven channel sets conflict status and half-bus bit.
// R20: Clearing output enable stops driving, listening and requesting the bus.
// R21: Interrupt output high when any flag and its enable are both set.
// R22: Hardware sets conflict flag on rising conflict, settled flag on settling.
`default_nettype none
package csrc_pkg;
   localparam logic [11:0] ADDR_CONTROL   = 12'h000;
   localparam logic [11:0] ADDR_CURPROG   = 12'h004;
   localparam logic [11:0] ADDR_DUTY      = 12'h00c;
   localparam logic [11:0] ADDR_STATUS    = 12'h018;
   localparam logic [11:0] ADDR_FLAGS     = 12'h020;
   localparam logic [11:0] ADDR_FLAG_SET  = 12'h024;
   localparam logic [11:0] ADDR_FLAG_CLR  = 12'h028;
   localparam logic [11:0] ADDR_IRQ_EN    = 12'h02c;
   localparam logic [11:0] ADDR_BUS_REQ   = 12'h034;
   localparam logic [11:0] ADDR_CONFLICT  = 12'h038;

   localparam int CTL_EN        = 0;
   localparam int CTL_SINK      = 1;
   localparam int CTL_MINTRANS  = 2;
   localparam int CTL_OUT_EN    = 3;
   localparam int CTL_SEL_LSB   = 4;
   localparam int CTL_SEL_MSB   = 11;
   localparam int CTL_SUPPLY    = 12;
   localparam int CTL_STOPDLY   = 13;
   localparam int CTL_MASTERDIS = 14;
   localparam int CTL_EVT_OE    = 16;
   localparam int CTL_CH_LSB    = 20;
   localparam int CTL_CH_MSB    = 23;
   localparam int RANGE_MSB     = 1;
   localparam int DUTY_STOPDIS  = 1;
   localparam int FLG_SETTLED   = 0;
   localparam int FLG_CONFLICT  = 1;
   localparam int REQ_X         = 2;
   localparam int REQ_Y         = 3;

   localparam logic [31:0] CTL_MASK   = 32'h00f1_7fff;
   localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
   localparam logic [7:0]  SEL_BASE   = 8'h20;
   localparam logic [7:0]  SEL_LAST   = 8'h3f;
   localparam logic [3:0]  EVT_LAST   = 4'hb;
   localparam int          NUM_EVT    = 12;

   // Output settling time after enable or reprogramming
   localparam int SETTLE_NS     = 5000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [9:0] SETTLE_CNT = 10'(SETTLE_CYC);

   typedef enum logic [1:0] {
      CSRC_IDLE     = 2'b00,
      CSRC_SETTLING = 2'b01,
      CSRC_STABLE   = 2'b11
   } csrc_state_t;
endpackage
`default_nettype wire

// ==== hw/csrc_reg_bank.sv ====
// Register bank and control of the current source, APB slave
//
// Design decision made here: the APB slave port.
`default_nettype none
module csrc_reg_bank (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [csrc_pkg::NUM_EVT-1:0] event_channels,
   input  wire logic                  read_clear_enable,
   input  wire logic                  other_x_request,
   input  wire logic                  other_y_request,
   input  wire logic                  ext_master_x,
   input  wire logic                  ext_master_y,
   input  wire logic                  stop_request,
   output logic                       source_enable,
   output logic                       output_enable,
   output logic      [7:0]            output_channel_select,
   output logic                       x_halfbus_requested,
   output logic                       y_halfbus_requested,
   output logic                       bus_drive,
   output logic                       sink_select,
   output logic                       supply_select,
   output logic                       min_transition_enable,
   output logic      [1:0]            range_select,
   output logic                       stop_duty_cycle_disable,
   output logic                       stop_entry_hold,
   output logic                       current_settled,
   output logic                       irq
);
   import csrc_pkg::*;

   logic [31:0]  control;
   logic [1:0]   current_program;
   logic         duty_cfg;
   logic [1:0]   flags;
   logic [1:0]   irq_en;
   logic         conflict_status;
   logic [1:0]   halfbus_conflict;
   logic         conflict_prev;
   logic [9:0]   settle_cnt;
   csrc_state_t  state;
   logic         setup;
   logic         wr;
   logic         rd;
   logic         next_oe;
   logic         sel_valid;
   logic         sel_y;
   logic         req_x;
   logic         req_y;
   logic         cfl_x;
   logic         cfl_y;
   logic [1:0]   set_hw;
   logic [1:0]   set_sw;
   logic [1:0]   clr_sw;
   logic         mapped;
   logic [31:0]  next_rdata;

   // Every access answers in its first access cycle
   assign setup = psel && !penable;
   assign wr    = psel && penable && pwrite;
   assign rd    = psel && penable && !pwrite;

   always_comb begin
      next_oe = control[CTL_OUT_EN];                                   // R6
      if (control[CTL_EVT_OE]) begin                                   // R1
         next_oe = 1'b0;
         if (control[CTL_CH_MSB:CTL_CH_LSB] <= EVT_LAST) begin         // R18
            next_oe = event_channels[control[CTL_CH_MSB:CTL_CH_LSB]];
         end
      end
   end

   assign sel_valid = (control[CTL_SEL_MSB:CTL_SEL_LSB] >= SEL_BASE) &&
                      (control[CTL_SEL_MSB:CTL_SEL_LSB] <= SEL_LAST);   // R5
   assign sel_y     = control[CTL_SEL_LSB];                             // R5
   // Slave mode follows the external master's selection, not our own
   assign req_x     = next_oe && (control[CTL_MASTERDIS] ? ext_master_x
                                                         : (sel_valid && !sel_y)); // R2 R20
   assign req_y     = next_oe && (control[CTL_MASTERDIS] ? ext_master_y
                                                         : (sel_valid && sel_y));  // R2 R20
   assign cfl_x     = req_x && other_x_request && !control[CTL_MASTERDIS];  // R19
   assign cfl_y     = req_y && other_y_request && !control[CTL_MASTERDIS];  // R19

   // Control register and its outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control         <= RESET_ZERO;
         current_program <= 2'h0;
         duty_cfg        <= 1'b0;
         irq_en          <= 2'h0;
      end else if (wr) begin
         case (paddr)
            ADDR_CONTROL: control         <= pwdata & CTL_MASK;         // R4 R7 R8
            ADDR_CURPROG: current_program <= pwdata[RANGE_MSB:0];       // R9
            ADDR_DUTY:    duty_cfg        <= pwdata[DUTY_STOPDIS];      // R10
            ADDR_IRQ_EN:  irq_en          <= pwdata[1:0];               // R16
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         source_enable           <= 1'b0;
         output_enable           <= 1'b0;
         output_channel_select   <= 8'h00;
         x_halfbus_requested     <= 1'b0;
         y_halfbus_requested     <= 1'b0;
         bus_drive               <= 1'b0;
         sink_select             <= 1'b0;
         supply_select           <= 1'b0;
         min_transition_enable   <= 1'b0;
         range_select            <= 2'h0;
         stop_duty_cycle_disable <= 1'b0;
         conflict_status         <= 1'b0;
         halfbus_conflict        <= 2'h0;
      end else begin
         source_enable           <= control[CTL_EN];
         output_enable           <= next_oe;
         output_channel_select   <= control[CTL_SEL_MSB:CTL_SEL_LSB];
         x_halfbus_requested     <= req_x;                              // R20
         y_halfbus_requested     <= req_y;                              // R17
         bus_drive               <= next_oe && sel_valid &&
                                    !control[CTL_MASTERDIS];            // R2
         sink_select             <= control[CTL_SINK];                  // R8
         supply_select           <= control[CTL_SUPPLY];                // R4
         min_transition_enable   <= control[CTL_MINTRANS] && !next_oe;  // R7
         range_select            <= current_program;                    // R9
         stop_duty_cycle_disable <= duty_cfg;                           // R10
         conflict_status         <= cfl_x || cfl_y;                     // R11
         halfbus_conflict        <= {cfl_y, cfl_x};                     // R19
      end
   end

   // Settling tracker for the output current
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state      <= CSRC_IDLE;
         settle_cnt <= 10'h000;
      end else begin
         case (state)
            CSRC_IDLE: begin
               if (control[CTL_EN]) begin
                  state      <= CSRC_SETTLING;
                  settle_cnt <= SETTLE_CNT;
               end
            end
            CSRC_SETTLING: begin
               if (!control[CTL_EN]) begin
                  state <= CSRC_IDLE;
               end else if (settle_cnt == 10'h001) begin
                  state <= CSRC_STABLE;
               end else begin
                  settle_cnt <= settle_cnt - 10'h001;
               end
            end
            CSRC_STABLE: begin
               if (!control[CTL_EN]) begin
                  state <= CSRC_IDLE;
               end else if (wr && paddr == ADDR_CURPROG) begin
                  state      <= CSRC_SETTLING;
                  settle_cnt <= SETTLE_CNT;
               end
            end
            default: state <= CSRC_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         current_settled <= 1'b0;
         stop_entry_hold <= 1'b0;
         conflict_prev   <= 1'b0;
      end else begin
         current_settled <= (state == CSRC_STABLE);
         stop_entry_hold <= control[CTL_STOPDLY] && stop_request &&
                            (state != CSRC_STABLE);                     // R3
         conflict_prev   <= conflict_status;
      end
   end

   // Flags: hardware and software sets win over clears
   assign set_hw = {conflict_status && !conflict_prev,
                    state == CSRC_SETTLING && settle_cnt == 10'h001};   // R22
   assign set_sw = (wr && paddr == ADDR_FLAG_SET) ? pwdata[1:0] : 2'h0; // R13
   always_comb begin
      clr_sw = 2'h0;
      if (wr && paddr == ADDR_FLAG_CLR) begin
         clr_sw = pwdata[1:0];                                          // R14
      end else if (rd && paddr == ADDR_FLAG_CLR && read_clear_enable) begin
         clr_sw = flags;                                                // R15
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= 2'h0;
      end else begin
         flags <= (flags & ~clr_sw) | set_sw | set_hw;                  // R12
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((flags & ~clr_sw) | set_sw | set_hw) & irq_en);      // R21
      end
   end

   // APB read path
   always_comb begin
      next_rdata = RESET_ZERO;
      mapped     = 1'b1;
      case (paddr)
         ADDR_CONTROL:  next_rdata = control;
         ADDR_CURPROG:  next_rdata[RANGE_MSB:0] = current_program;
         ADDR_DUTY:     next_rdata[DUTY_STOPDIS] = duty_cfg;
         ADDR_STATUS:   next_rdata[FLG_CONFLICT] = conflict_status;     // R11
         ADDR_FLAGS:    next_rdata[1:0] = flags;                        // R12
         ADDR_FLAG_SET: next_rdata = RESET_ZERO;
         ADDR_FLAG_CLR: next_rdata[1:0] = read_clear_enable ? flags : 2'h0;  // R15
         ADDR_IRQ_EN:   next_rdata[1:0] = irq_en;
         ADDR_BUS_REQ: begin
            next_rdata[REQ_X] = x_halfbus_requested;
            next_rdata[REQ_Y] = y_halfbus_requested;                    // R17
         end
         ADDR_CONFLICT: next_rdata[REQ_Y:REQ_X] = halfbus_conflict;     // R19
         default:       mapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= RESET_ZERO;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup && !mapped;
         prdata  <= (setup && !pwrite) ? next_rdata : RESET_ZERO;
      end
   end

   // Assertions
   property p_evt_oe;
      @(posedge pclk) disable iff (!presetn)
      control[CTL_EVT_OE] && control[CTL_CH_MSB:CTL_CH_LSB] <= EVT_LAST
         |=> output_enable == $past(event_channels[control[CTL_CH_MSB:CTL_CH_LSB]]);
   endproperty
   a_evt_oe: assert property (p_evt_oe) else $error("event oe mismatch"); // R1

   property p_sw_oe;
      @(posedge pclk) disable iff (!presetn)
      !control[CTL_EVT_OE] |=> output_enable == $past(control[CTL_OUT_EN]);
   endproperty
   a_sw_oe: assert property (p_sw_oe) else $error("software oe mismatch"); // R6

   property p_slave_nodrive;
      @(posedge pclk) disable iff (!presetn)
      control[CTL_MASTERDIS] |=> !bus_drive && !conflict_status;
   endproperty
   a_slave_nodrive: assert property (p_slave_nodrive) else $error("slave drives"); // R2

   property p_slave_req;
      @(posedge pclk) disable iff (!presetn)
      control[CTL_MASTERDIS] && next_oe
         |=> x_halfbus_requested == $past(ext_master_x) &&
             y_halfbus_requested == $past(ext_master_y);
   endproperty
   a_slave_req: assert property (p_slave_req) else $error("slave request mismatch"); // R2

   property p_oe_off;
      @(posedge pclk) disable iff (!presetn)
      !next_oe |=> !x_halfbus_requested && !y_halfbus_requested && !bus_drive;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("bus held when off"); // R20

   property p_conflict_flag;
      @(posedge pclk) disable iff (!presetn)
      $rose(conflict_status) |=> flags[FLG_CONFLICT];
   endproperty
   a_conflict_flag: assert property (p_conflict_flag) else $error("flag not set"); // R22

   property p_flag_set;
      @(posedge pclk) disable iff (!presetn)
      wr && paddr == ADDR_FLAG_SET && pwdata[FLG_SETTLED] |=> flags[FLG_SETTLED];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("w1s failed"); // R13

   property p_flag_clr;
      @(posedge pclk) disable iff (!presetn)
      wr && paddr == ADDR_FLAG_CLR && pwdata[FLG_CONFLICT] && !set_hw[FLG_CONFLICT]
         |=> !flags[FLG_CONFLICT];
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("w1c failed"); // R14

   property p_irq;
      @(posedge pclk) disable iff (!presetn)
      ##1 irq == |($past(flags & ~clr_sw | set_sw | set_hw) & $past(irq_en));
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch"); // R21

   property p_ready;
      @(posedge pclk) disable iff (!presetn)
      setup |=> pready ##1 !pready;
   endproperty
   a_ready: assert property (p_ready) else $error("pready timing"); // APB ready timing

   c_conflict: cover property (@(posedge pclk) disable iff (!presetn) $rose(conflict_status));
   c_settled:  cover property (@(posedge pclk) disable iff (!presetn) $rose(current_settled));
   c_rdclr:    cover property (@(posedge pclk) disable iff (!presetn)
                               rd && paddr == ADDR_FLAG_CLR && read_clear_enable && |flags);
endmodule // csrc_reg_bank
`default_nettype wire

// ==== testbench/csrc_reg_bank_tb_top.sv ====
// Self-checking bench for the current source register bank
`default_nettype none
module csrc_reg_bank_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import csrc_pkg::*;

   logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0]        paddr;
   logic [31:0]        pwdata, prdata;
   logic [NUM_EVT-1:0] event_channels;
   logic               read_clear_enable, other_x_request, other_y_request;
   logic               ext_master_x, ext_master_y, stop_request, source_enable;
   logic               output_enable, x_halfbus_requested, y_halfbus_requested, bus_drive;
   logic               sink_select, supply_select, min_transition_enable;
   logic [7:0]         output_channel_select;
   logic [1:0]         range_select;
   logic               stop_duty_cycle_disable, stop_entry_hold, current_settled, irq;
   int                 errors, compares, seed;

   csrc_reg_bank dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .event_channels(event_channels), .read_clear_enable(read_clear_enable),
      .other_x_request(other_x_request), .other_y_request(other_y_request),
      .ext_master_x(ext_master_x), .ext_master_y(ext_master_y),
      .stop_request(stop_request), .source_enable(source_enable),
      .output_enable(output_enable), .output_channel_select(output_channel_select),
      .x_halfbus_requested(x_halfbus_requested), .y_halfbus_requested(y_halfbus_requested),
      .bus_drive(bus_drive), .sink_select(sink_select), .supply_select(supply_select),
      .min_transition_enable(min_transition_enable), .range_select(range_select),
      .stop_duty_cycle_disable(stop_duty_cycle_disable), .stop_entry_hold(stop_entry_hold),
      .current_settled(current_settled), .irq(irq)
   );

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic test_done;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One APB transfer, entered just after a rising edge, idle cycle at the end
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      chk({31'h0, pready}, 32'h1, "pready");
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r & m, exp, $sformatf("reg %h", a));
   endtask

   // Expected {output enable, x req, y req, x conflict, y conflict, drive}
   function automatic logic [5:0] link(input logic [31:0] c, input logic [11:0] ev,
                                       input logic ox, input logic oy,
                                       input logic ex, input logic ey);
      logic oe, inr, md, xr, yr;
      oe  = c[CTL_EVT_OE] ? (c[23:20] <= EVT_LAST && ev[c[23:20]]) : c[CTL_OUT_EN];
      inr = c[11:4] >= SEL_BASE && c[11:4] <= SEL_LAST;
      md  = c[CTL_MASTERDIS];
      xr  = oe && (md ? ex : (inr && !c[4]));
      yr  = oe && (md ? ey : (inr && c[4]));
      return {oe, xr, yr, !md && xr && ox, !md && yr && oy, oe && inr && !md};
   endfunction

   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      test_done();
   end

   initial begin
      logic [31:0] c, r;
      logic [5:0]  lk;
      logic        e;
      seed = 32'hfe2c;
      errors = 0;
      compares = 0;
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      {event_channels, read_clear_enable, other_x_request, other_y_request} = '0;
      {ext_master_x, ext_master_y, stop_request} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({10'h0, source_enable, output_enable, output_channel_select, x_halfbus_requested,
           y_halfbus_requested, bus_drive, sink_select, supply_select, min_transition_enable,
           range_select, stop_duty_cycle_disable, stop_entry_hold, current_settled, irq},
          32'h0, "reset outs");
      rdchk(ADDR_CONTROL, 32'hffff_ffff, 32'h0);
      rdchk(ADDR_CURPROG, 32'h0000_ffff, 32'h0);
      rdchk(ADDR_DUTY, 32'hffff_ffff, 32'h0);
      rdchk(ADDR_STATUS, 32'hffff_ffff, 32'h0);
      rdchk(ADDR_FLAGS, 32'hffff_ffff, 32'h0);
      rdchk(ADDR_IRQ_EN, 32'hffff_ffff, 32'h0);
      rdchk(ADDR_BUS_REQ, 32'hffff_ffff, 32'h0);
      apb(1'b0, 12'h010, 32'h0, r, e);
      chk({r[30:0], e}, 32'h1, "unmapped");
      for (int i = 0; i < 24; i++) begin
         c = $random(seed);
         c[11:4] = (i == 0) ? 8'h1f : (i == 1) ? 8'h40 : {3'b001, c[8:4]};
         event_channels  <= 12'($random(seed));
         other_x_request <= 1'($random(seed));
         other_y_request <= 1'($random(seed));
         ext_master_x    <= 1'($random(seed));
         ext_master_y    <= 1'($random(seed));
         stop_request    <= 1'($random(seed));
         wr(ADDR_CONTROL, c);
         wr(ADDR_CURPROG, {30'h0, c[25:24]});
         wr(ADDR_DUTY, {30'h0, c[26], 1'b0});
         repeat (4) @(posedge pclk);
         lk = link(c, event_channels, other_x_request, other_y_request,
                   ext_master_x, ext_master_y);
         chk({output_enable, x_halfbus_requested, y_halfbus_requested}, lk[5:3], "oe");
         chk({17'h0, source_enable, sink_select, supply_select, min_transition_enable,
              output_channel_select, range_select, stop_duty_cycle_disable},
             {17'h0, c[CTL_EN], c[CTL_SINK], c[CTL_SUPPLY], c[CTL_MINTRANS] & ~lk[5],
              c[11:4], c[25:24], c[26]}, "config");
         chk({31'h0, bus_drive}, {31'h0, lk[0]}, "drive");
         rdchk(ADDR_STATUS, 32'h2, {30'h0, lk[2] | lk[1], 1'b0});
         rdchk(ADDR_CONFLICT, 32'hc, {28'h0, lk[1], lk[2], 2'b00});
         rdchk(ADDR_BUS_REQ, 32'hc, {28'h0, lk[3], lk[4], 2'b00});
         rdchk(ADDR_CONTROL, 32'hffff_ffff, c & CTL_MASK);
      end
      {event_channels, other_x_request, other_y_request} <= '0;
      wr(ADDR_CONTROL, 32'h0);
      stop_request <= 1'b1;
      wr(ADDR_FLAG_CLR, 32'h3);
      wr(ADDR_CONTROL, 32'h0000_2001);
      repeat (5) @(posedge pclk);
      chk({30'h0, stop_entry_hold, current_settled}, 32'h2, "hold");
      repeat (SETTLE_CYC + 10) @(posedge pclk);
      chk({30'h0, stop_entry_hold, current_settled}, 32'h1, "settled");
      rdchk(ADDR_FLAGS, 32'h1, 32'h1);
      wr(ADDR_CONTROL, 32'h0);
      stop_request <= 1'b0;
      for (int f = 0; f < 4; f++) begin
         for (int en = 0; en < 4; en++) begin
            wr(ADDR_FLAG_CLR, 32'h3);
            wr(ADDR_FLAG_SET, 32'(f));
            wr(ADDR_IRQ_EN, 32'(en));
            wr(ADDR_FLAGS, 32'h3);
            chk({31'h0, irq}, ((f & en) != 0) ? 32'h1 : 32'h0, "irq");
            rdchk(ADDR_FLAGS, 32'h3, 32'(f));
            rdchk(ADDR_IRQ_EN, 32'hffff_ffff, 32'(en));
         end
      end
      wr(ADDR_FLAG_CLR, 32'h0);
      rdchk(ADDR_FLAGS, 32'h3, 32'h3);
      wr(ADDR_FLAG_CLR, 32'h2);
      rdchk(ADDR_FLAGS, 32'h3, 32'h1);
      read_clear_enable <= 1'b1;
      wr(ADDR_FLAG_SET, 32'h3);
      rdchk(ADDR_FLAG_CLR, 32'h3, 32'h3);
      rdchk(ADDR_FLAGS, 32'h3, 32'h0);
      read_clear_enable <= 1'b0;
      wr(ADDR_IRQ_EN, 32'h2);
      wr(ADDR_CONTROL, 32'h0000_0218);
      other_y_request <= 1'b1;
      repeat (5) @(posedge pclk);
      rdchk(ADDR_FLAGS, 32'h3, 32'h2);
      chk({31'h0, irq}, 32'h1, "conflict irq");
      test_done();
   end
endmodule // csrc_reg_bank_tb_top
`default_nettype wire
